// file: rtl/nfbi_regs.svh
// timing counts and field constants for the nand strobe controller
`ifndef NFBI_REGS_SVH
`define NFBI_REGS_SVH
`define NFBI_CLK_MHZ        200
`define NFBI_RECOVERY_NS    1000
`define NFBI_RECOVERY_CYC   ((`NFBI_RECOVERY_NS * `NFBI_CLK_MHZ + 999) / 1000)
`define NFBI_ADDR_CYCLES    3
`define NFBI_DEF_PULSE      4
`define NFBI_DEF_GAP        4
`endif

// file: rtl/nfbi_pkg.sv
// types for the nand strobe controller
package nfbi_pkg;
	typedef enum logic [1:0] {
		NFBI_OP_CMD  = 2'h0,
		NFBI_OP_ADDR = 2'h1,
		NFBI_OP_WR   = 2'h2,
		NFBI_OP_RD   = 2'h3
	} nfbi_op_t;
	typedef struct packed {
		nfbi_op_t    op;
		logic [15:0] data;
	} nfbi_req_t;
	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic out_strobe_n;
		logic we_n;
		logic wp_n;
	} nfbi_pins_t;
	typedef enum logic [5:0] {
		NFBI_ST_POWER = 6'h01,
		NFBI_ST_IDLE  = 6'h02,
		NFBI_ST_SETUP = 6'h04,
		NFBI_ST_PULSE = 6'h08,
		NFBI_ST_HOLD  = 6'h10,
		NFBI_ST_DONE  = 6'h20
	} nfbi_state_t;
endpackage : nfbi_pkg

// file: rtl/nfbi_host.sv
// host controller driving the nand flash strobe interface
`include "nfbi_regs.svh"
// How it works
// - upper byte carries only data words
// - keep select low through read busy
// - hold write strobe high during recovery
// - hold protect low during power transitions
// - command needs ce low, cle high, ale low
// - address takes exactly three byte cycles; the host does not count them and sends one cycle per ADDR request
// - write data with both latches low
// - address bytes A0-7, A9-16, A17-24
module nfbi_host
	import nfbi_pkg::*;
#(
	parameter int unsigned WIDE    = 0,
	parameter int unsigned CNT_W   = 8,
	parameter int unsigned RECOVER = `NFBI_RECOVERY_CYC
)(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        reqValid,
	input  wire nfbi_req_t   req,
	input  wire logic        reqLast,
	input  wire logic        protEnable,
	input  wire logic        spareSkip,
	input  wire logic [CNT_W-1:0] pulseCycles,
	input  wire logic [CNT_W-1:0] gapCycles,
	output nfbi_pins_t       pins,
	output logic             spare_incl_sel,
	output logic [15:0]      ioOut,
	output logic [15:0]      ioOe,
	input  wire logic [15:0] ioIn,
	input  wire logic        busy_n_line,
	output logic             reqReady,
	output logic             rdValid,
	output logic [15:0]      rdData,
	output logic             devBusy
);
	nfbi_state_t state, next_state;
	nfbi_pins_t  next_pins;
	nfbi_req_t   cur, next_cur;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [15:0] rec, next_rec;
	logic [15:0] next_ioOut, next_ioOe, next_rdData;
	logic        next_reqReady, next_rdValid, next_spare;
	logic        next_hold;
	logic        holdCe;
	logic        busySync1, busySync2;
	logic [15:0] ioSync1, ioSync2;

	// two-flop synchronisers for pin inputs
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			busySync1 <= 1'b1;
			busySync2 <= 1'b1;
			ioSync1   <= 16'h0000;
			ioSync2   <= 16'h0000;
		end
		else
		begin
			busySync1 <= busy_n_line;
			busySync2 <= busySync1;
			ioSync1   <= ioIn;
			ioSync2   <= ioSync1;
		end
	end

	always_comb
	begin
		next_state    = state;
		next_pins     = pins;
		next_cur      = cur;
		next_cnt      = cnt;
		next_rec      = rec;
		next_ioOut    = ioOut;
		next_ioOe     = ioOe;
		next_rdData   = rdData;
		next_rdValid  = 1'b0;
		next_reqReady = 1'b0;
		next_hold     = holdCe;
		next_spare    = spareSkip;
		next_pins.wp_n = ~protEnable;
		unique case (state)
			NFBI_ST_POWER:
			begin
				next_pins.we_n = 1'b1;
				next_pins.wp_n = 1'b0;
				if (rec == 16'(RECOVER))
				begin
					next_state    = NFBI_ST_IDLE;
					next_reqReady = 1'b1;
				end
				else
					next_rec = rec + 16'h0001;
			end
			NFBI_ST_IDLE:
			begin
				next_reqReady = 1'b1;
				// ce stays low across read busy so a sequential read is not aborted
				next_pins.ce_n = ~holdCe;
				if (reqValid && reqReady)
				begin
					next_reqReady  = 1'b0;
					next_cur       = req;
					next_hold      = ~reqLast;
					next_pins.ce_n = 1'b0;
					next_pins.cle  = (req.op == NFBI_OP_CMD);
					next_pins.ale  = (req.op == NFBI_OP_ADDR);
					next_pins.out_strobe_n = 1'b1;
					next_pins.we_n = 1'b1;
					next_ioOut     = (req.op == NFBI_OP_WR) ? req.data : {8'h00, req.data[7:0]};
					next_ioOe      = (req.op == NFBI_OP_RD) ? 16'h0000 :
						((req.op == NFBI_OP_WR && WIDE != 0) ? 16'hffff : 16'h00ff);
					next_cnt       = gapCycles;
					next_state     = NFBI_ST_SETUP;
				end
			end
			NFBI_ST_SETUP:
			begin
				// wait for the shared busy line before each new cycle
				if (cnt != '0)
					next_cnt = cnt - CNT_W'(1);
				else if (busySync2)
				begin
					if (cur.op == NFBI_OP_RD)
						next_pins.out_strobe_n = 1'b0;
					else
						next_pins.we_n = 1'b0;
					next_cnt   = pulseCycles;
					next_state = NFBI_ST_PULSE;
				end
			end
			NFBI_ST_PULSE:
			begin
				if (cnt != '0)
					next_cnt = cnt - CNT_W'(1);
				else
				begin
					if (cur.op == NFBI_OP_RD)
						next_rdData = (WIDE != 0) ? ioSync2 : {8'h00, ioSync2[7:0]};
					next_pins.out_strobe_n = 1'b1;
					next_pins.we_n = 1'b1;
					next_cnt       = gapCycles;
					next_state     = NFBI_ST_HOLD;
				end
			end
			NFBI_ST_HOLD:
			begin
				if (cnt != '0)
					next_cnt = cnt - CNT_W'(1);
				else
				begin
					// latches drop only after the hold time; idle levels otherwise
					next_pins.cle = 1'b0;
					next_pins.ale = 1'b0;
					next_ioOe     = 16'h0000;
					next_rdValid  = (cur.op == NFBI_OP_RD);
					next_state    = NFBI_ST_DONE;
				end
			end
			NFBI_ST_DONE:
			begin
				next_reqReady = 1'b1;
				next_state    = NFBI_ST_IDLE;
			end
			default:
				next_state = NFBI_ST_POWER;
		endcase
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state          <= NFBI_ST_POWER;
			pins           <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, out_strobe_n: 1'b1, we_n: 1'b1, wp_n: 1'b0};
			cur            <= '0;
			cnt            <= '0;
			rec            <= 16'h0000;
			ioOut          <= 16'h0000;
			ioOe           <= 16'h0000;
			rdData         <= 16'h0000;
			rdValid        <= 1'b0;
			reqReady       <= 1'b0;
			holdCe         <= 1'b0;
			spare_incl_sel <= 1'b0;
			devBusy        <= 1'b0;
		end
		else
		begin
			state          <= next_state;
			pins           <= next_pins;
			cur            <= next_cur;
			cnt            <= next_cnt;
			rec            <= next_rec;
			ioOut          <= next_ioOut;
			ioOe           <= next_ioOe;
			rdData         <= next_rdData;
			rdValid        <= next_rdValid;
			reqReady       <= next_reqReady;
			holdCe         <= next_hold;
			spare_incl_sel <= next_spare;
			devBusy        <= ~busySync2;
		end
	end

	a_recovery_we: assert property (@(posedge clock) disable iff (!nrst)
		(state == NFBI_ST_POWER) |-> pins.we_n && !reqReady) else $error("write strobe low in recovery");
	a_cmd_levels: assert property (@(posedge clock) disable iff (!nrst)
		$rose(pins.we_n) && pins.cle |-> !pins.ce_n && !pins.ale && pins.out_strobe_n) else $error("bad command levels");
	a_addr_levels: assert property (@(posedge clock) disable iff (!nrst)
		$rose(pins.we_n) && pins.ale |-> !pins.ce_n && !pins.cle && pins.out_strobe_n) else $error("bad address levels");
	a_data_levels: assert property (@(posedge clock) disable iff (!nrst)
		$fell(pins.we_n) && !pins.cle && !pins.ale |-> !pins.ce_n && pins.out_strobe_n) else $error("bad data levels");
	a_read_levels: assert property (@(posedge clock) disable iff (!nrst)
		$fell(pins.out_strobe_n) |-> !pins.ce_n && pins.we_n && !pins.cle && !pins.ale) else $error("bad read levels");
	a_read_undriven: assert property (@(posedge clock) disable iff (!nrst)
		!pins.out_strobe_n |-> ioOe == 16'h0000) else $error("bus driven during read");
	a_busy_wait: assert property (@(posedge clock) disable iff (!nrst)
		$fell(pins.we_n) || $fell(pins.out_strobe_n) |-> $past(busySync2)) else $error("strobe while busy");
	a_upper_quiet: assert property (@(posedge clock) disable iff (!nrst)
		(pins.cle || pins.ale) && ioOe != 16'h0000 |-> ioOe == 16'h00ff) else $error("upper byte on cmd");
	a_prot_live: assert property (@(posedge clock) disable iff (!nrst)
		(state != NFBI_ST_POWER) && (next_state != NFBI_ST_POWER) |=> pins.wp_n == !$past(protEnable))
		else $error("protect not live");
endmodule : nfbi_host

// file: sim/nfbi_flash_model.sv
// behavioural nand device answering the strobe controller
module nfbi_flash_model
	import nfbi_pkg::*;
(
	input  wire nfbi_pins_t  pins,
	input  wire logic        spare_incl_sel,
	input  wire logic [15:0] hostIo,
	output logic [15:0]      devIo,
	output logic             busy_n_line
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] seen[$];
	int          col   = 0;
	int          progs = 0;
	logic        supplyOk = 1'b1; // supply above the lockout level
	initial
	begin
		devIo       = 16'h5a5a;
		busy_n_line = 1'b1;
	end
	// log upper byte: 1 command, 2 address, 3 data
	always @(posedge pins.we_n)
	begin
		if (supplyOk && !pins.ce_n && pins.out_strobe_n)
		begin
			if (pins.cle && !pins.ale)
			begin
				seen.push_back({8'h01, hostIo[7:0]});
				col = 0;
				if (hostIo[7:0] == 8'h10 && pins.wp_n)
				begin
					progs++;
					busy_n_line = 1'b0;
					busy_n_line <= #60 1'b1;
				end
			end
			else if (pins.ale && !pins.cle)
				seen.push_back({8'h02, hostIo[7:0]});
			else if (!pins.ale && !pins.cle)
				seen.push_back({8'h03, hostIo[7:0]});
		end // anything else is idle
	end
	always @(negedge pins.out_strobe_n)
		if (supplyOk && !pins.ce_n && pins.we_n && !pins.cle && !pins.ale)
		begin
			devIo = {8'h00, 8'h3c + col[7:0]};
			col++;
			// page end wraps, spare bytes only when spare_incl_sel is low (528 columns, else 512)
			if (col == (spare_incl_sel ? 512 : 528))
				col = 0;
		end
	// released bus must not look like valid data
	always @(posedge pins.out_strobe_n or posedge pins.ce_n)
		devIo = ~devIo;
endmodule : nfbi_flash_model

// file: sim/testbench.sv
// self-checking bench for the nand strobe controller
module testbench
	import nfbi_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock = 1'b0, nrst = 1'b0, reqValid = 1'b0, reqLast = 1'b1;
	logic        protEnable = 1'b1, spareSkip = 1'b0;
	nfbi_req_t   req = '0;
	logic [7:0]  pulseCycles = 8'h06, gapCycles = 8'h02;
	nfbi_pins_t  pins;
	logic        spare_incl_sel, rdValid, reqReady, devBusy, busy_n_line;
	logic [15:0] ioOut, ioOe, rdData, devIo;
	logic [15:0] expq[$], exprd[$];
	int          miscompares = 0, num_checks = 0, seed = 12979, busySeen = 0;
	always #2.5 clock = ~clock;
	nfbi_host #(.RECOVER(4)) u_dut(.clock(clock), .nrst(nrst), .reqValid(reqValid), .req(req),
		.reqLast(reqLast), .protEnable(protEnable), .spareSkip(spareSkip), .pulseCycles(pulseCycles),
		.gapCycles(gapCycles), .pins(pins), .spare_incl_sel(spare_incl_sel), .ioOut(ioOut), .ioOe(ioOe),
		.ioIn(devIo), .busy_n_line(busy_n_line), .reqReady(reqReady), .rdValid(rdValid),
		.rdData(rdData), .devBusy(devBusy));
	nfbi_flash_model u_mod(.pins(pins), .spare_incl_sel(spare_incl_sel), .hostIo(ioOut), .devIo(devIo),
		.busy_n_line(busy_n_line));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic send(input nfbi_op_t op, input logic [15:0] d, input logic last);
		int n;
		n = 0;
		while (reqReady !== 1'b1 && n < 4000)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 4000)
			miscompares++;
		if (op != NFBI_OP_RD)
			expq.push_back({6'h00, op + 2'h1, d[7:0]});
		req      = '{op, d};
		reqLast  = last;
		reqValid = 1'b1;
		@(posedge clock);
		#1;
		reqValid = 1'b0;
	endtask : send
	task automatic drain(input string name);
		send(NFBI_OP_CMD, 16'h00ff, 1'b1);
		repeat (40) @(posedge clock);
		#1;
		check(16'(u_mod.seen.size()), 16'(expq.size()));
		while (expq.size() > 0 && u_mod.seen.size() > 0)
			check(u_mod.seen.pop_front(), expq.pop_front());
		$display("test %s done", name);
	endtask : drain
	task automatic program_page(input string name);
		send(NFBI_OP_CMD, 16'h0080, 1'b0);
		repeat (3) send(NFBI_OP_ADDR, 16'($random(seed)), 1'b0);
		repeat (4) send(NFBI_OP_WR, 16'($random(seed)), 1'b0);
		send(NFBI_OP_CMD, 16'h0010, 1'b1);
		drain(name);
	endtask : program_page
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	always @(posedge clock)
	begin
		if (devBusy === 1'b1)
			busySeen++;
		if (rdValid === 1'b1)
			check(rdData, exprd.pop_front());
	end
	initial
	begin
		#100000;
		miscompares++;
		test_done;
	end
	initial
	begin
		repeat (2) @(posedge clock);
		#1;
		nrst = 1'b1;
		@(posedge clock);
		#1;
		check({15'h0, pins.wp_n}, 16'h0000);
		check({15'h0, pins.we_n}, 16'h0001);
		protEnable = 1'b0;
		program_page("open");
		check(16'(u_mod.progs), 16'h0001);
		check({15'h0, busySeen != 0}, 16'h0001);
		protEnable = 1'b1;
		program_page("locked");
		check(16'(u_mod.progs), 16'h0001);
		send(NFBI_OP_CMD, 16'h0000, 1'b0);
		repeat (3) send(NFBI_OP_ADDR, 16'($random(seed)), 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			exprd.push_back({8'h00, 8'h3c + 8'(i)});
			send(NFBI_OP_RD, 16'h0000, i == 3);
		end
		drain("read");
		check({15'h0, pins.ce_n}, 16'h0001);
		spareSkip = 1'b1;
		repeat (3) @(posedge clock);
		#1;
		check({15'h0, spare_incl_sel}, 16'h0001);
		$display("test spare done");
		test_done;
	end
endmodule : testbench
